/* verilog/dbcr_block.sv */
// One configurable 8-bit digital block: input selectors, clock resync,
// a compact datapath and the two output drivers onto the row bus.
// Assumes system clocks, dividers and row signals arrive as async levels.
// How it works
// R1: Clock and data each via sixteen-way selector
// R2: Four-way slave-select selector, enable forces active
// R3: Sources: dividers, 24M, 48M, rows, blocks
// R4: Sync code 00 uses input unsynchronized
// R5: Sync code 01 resyncs to 24M clock
// R6: Sync code 10 resyncs to 48M clock
// R7: Sync code 11 clocks directly from 24M
// R8: Selecting 48M source clocks block directly; under sync code 11 the code clocks it from 24M instead
// R9: Same-frequency input yields no clock events
// R10: Software avoids resyncing divide-by-one clocks
// R11: Sleep stops resync; only bypass keeps running
// R12: Software uses bypass rarely, syncs via interrupts
// R13: Each output drives one of four row drivers
// R14: Functions: timer, counter, PWM, PRS, CRC, comms
// R15: Blocks chain for widths above eight bits
// R16: Seven registers steer independent block function
// R17: Own interrupt mask and own request line
// R18: Input clock rise gives one enable pulse
`timescale 1ns/1ps
module dbcr_block
   import dbcr_pkg::*;
#(
   parameter bit COMMS_CAPABLE = 1'b1
) (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic [15:0] clockSources,
   input  wire logic [15:0] dataSources,
   input  wire logic [3:0]  auxSources,
   input  wire logic        system_clock_24m,
   input  wire logic        system_clock_48m,
   input  wire logic        sleepMode,
   input  wire logic [2:0]  functionSelect,
   input  wire logic [1:0]  functionMode,
   input  wire logic [3:0]  clockSelect,
   input  wire logic [3:0]  dataSelect,
   input  wire logic [1:0]  input_sync_select,
   input  wire logic [1:0]  auxInputSelect,
   input  wire logic        auxIoEnable,
   input  wire logic [1:0]  primaryDriverSelect,
   input  wire logic        primaryDriverEnable,
   input  wire logic [1:0]  auxDriverSelect,
   input  wire logic        auxDriverEnable,
   input  wire logic        writeStrobe,
   input  wire logic [1:0]  writeSelect,
   input  wire logic [7:0]  writeData,
   input  wire logic        chainIn,
   input  wire logic        irqMask,
   output logic [7:0]       countValue,
   output logic [7:0]       compareValue,
   output logic             chainOut,
   output logic             irqRequest,
   output logic             slaveSelectN,
   output logic [3:0]       primaryRowOut,
   output logic [3:0]       primaryRowOutEn,
   output logic [3:0]       auxRowOut,
   output logic [3:0]       auxRowOutEn
);
   initial begin
      if (`DBCR_SRC_ROW_BASE > 4'hf) $error("dbcr_block: bad row base");
   end

   // ************************************************************
   // Input selection and synchronization
   // ************************************************************
   dbcr_sync_if #(.LANES(`DBCR_LANES)) syncIf ();

   // Selectors sit ahead of the synchronizer so only six lanes are paid for
   assign syncIf.raw = {sleepMode, system_clock_48m, system_clock_24m,
                        auxSources[auxInputSelect],      // R2
                        dataSources[dataSelect],         // R1
                        clockSources[clockSelect]};      // R1 R3

   dbcr_edge_sync #(.LANES(`DBCR_LANES)) u_sync (
      .core_clk (core_clk),
      .rstn     (rstn),
      .port     (syncIf)
   );

   logic tick24;
   logic tick48;
   logic asleep;
   logic clkSel48;
   assign tick24   = syncIf.rise[`DBCR_LN_24M];
   assign tick48   = syncIf.rise[`DBCR_LN_48M];
   assign asleep   = syncIf.level[`DBCR_LN_SLEEP];
   assign clkSel48 = (clockSelect == `DBCR_SRC_48M);

   // ************************************************************
   // Clock resynchronizer
   // ************************************************************
   logic sample_reg;
   logic sample_next;
   logic held_reg;
   logic held_next;
   logic clkEvent_reg;
   logic clkEvent_next;
   logic masterTick;

   always_comb begin
      masterTick = (input_sync_select == `DBCR_SYNC_48M) ? tick48 : tick24;
      sample_next = sample_reg;
      held_next   = held_reg;
      // Input is only looked at on the master edge, so an input of equal
      // frequency is seen at one phase forever and never rises
      if (masterTick) begin
         sample_next = syncIf.level[`DBCR_LN_CLK];                  // R9
         held_next   = sample_reg;
      end
      clkEvent_next = 1'b0;
      if (clkSel48 && input_sync_select != `DBCR_SYNC_DIRECT) begin
         clkEvent_next = tick48 && !asleep;                          // R8
      end else begin
         unique case (input_sync_select)
            `DBCR_SYNC_BYPASS: clkEvent_next = syncIf.rise[`DBCR_LN_CLK]; // R4 R11
            `DBCR_SYNC_24M:    clkEvent_next = masterTick && sample_reg
                                               && !held_reg && !asleep;   // R5 R18
            `DBCR_SYNC_48M:    clkEvent_next = masterTick && sample_reg
                                               && !held_reg && !asleep;   // R6 R18
            `DBCR_SYNC_DIRECT: clkEvent_next = tick24 && !asleep;         // R7
         endcase
      end
   end

   // The resync stages carry no function state, yet reset keeps them known
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         sample_reg   <= 1'b0;
         held_reg     <= 1'b0;
         clkEvent_reg <= 1'b0;
      end else begin
         sample_reg   <= sample_next;
         held_reg     <= held_next;
         clkEvent_reg <= clkEvent_next;
      end
   end

   // ************************************************************
   // Datapath: count, period, compare and control registers
   // ************************************************************
   dbcr_byte_t count_reg;
   dbcr_byte_t count_next;
   dbcr_byte_t period_reg;
   dbcr_byte_t period_next;
   dbcr_byte_t compare_reg;
   dbcr_byte_t compare_next;
   dbcr_byte_t control_reg;
   dbcr_byte_t control_next;
   dbcr_run_t  run;
   logic       dataLevel;
   logic       dataRise;
   logic       terminal;
   logic       compareHit;
   logic       advance;
   logic       feedback;

   assign run       = control_reg[`DBCR_CTL_ENABLE] ? DBCR_RUNNING : DBCR_STOPPED;
   assign dataLevel = syncIf.level[`DBCR_LN_DATA];
   assign dataRise  = syncIf.rise[`DBCR_LN_DATA];
   assign terminal  = (count_reg == `DBCR_BYTE_RST);
   assign compareHit = functionMode[`DBCR_MODE_CMP] ? (count_reg <= compare_reg)
                                                    : (count_reg < compare_reg);

   always_comb begin
      count_next   = count_reg;
      period_next  = period_reg;
      compare_next = compare_reg;
      control_next = control_reg;
      feedback     = 1'b0;
      // Counter-like functions count only while the chain input allows
      advance = clkEvent_reg && (run == DBCR_RUNNING) && chainIn;    // R15
      if (functionSelect == `DBCR_FN_COUNTER || functionSelect == `DBCR_FN_PWM) begin
         advance = advance && dataLevel;
      end
      if (advance) begin
         unique case (functionSelect)
            `DBCR_FN_PRS: begin
               feedback   = count_reg[7];
               count_next = {count_reg[6:0], 1'b0} ^ (feedback ? period_reg : 8'h00); // R14
            end
            `DBCR_FN_CRC: begin
               feedback   = count_reg[7] ^ dataLevel;
               count_next = {count_reg[6:0], 1'b0} ^ (feedback ? period_reg : 8'h00); // R14
            end
            `DBCR_FN_TIMER, `DBCR_FN_COUNTER, `DBCR_FN_PWM: begin
               count_next = terminal ? period_reg : count_reg - 8'h01;               // R14
            end
            default: count_next = count_reg;
         endcase
      end
      // Hardware capture copies the count into the compare register
      if (functionSelect == `DBCR_FN_TIMER && run == DBCR_RUNNING && dataRise) begin
         compare_next = count_reg;
      end
      if (writeStrobe) begin
         unique case (writeSelect)
            `DBCR_WR_COUNT:   count_next = writeData;                                // R16
            `DBCR_WR_PERIOD: begin
               period_next = writeData;
               if (run == DBCR_STOPPED) begin
                  count_next = writeData;
               end
            end
            `DBCR_WR_COMPARE: begin
               if (run == DBCR_STOPPED || functionSelect != `DBCR_FN_TIMER) begin
                  compare_next = writeData;
               end
            end
            `DBCR_WR_CONTROL: control_next = writeData;                              // R16
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         count_reg   <= `DBCR_BYTE_RST;
         period_reg  <= `DBCR_BYTE_RST;
         compare_reg <= `DBCR_BYTE_RST;
         control_reg <= `DBCR_BYTE_RST;
      end else begin
         count_reg   <= count_next;
         period_reg  <= period_next;
         compare_reg <= compare_next;
         control_reg <= control_next;
      end
   end

   // ************************************************************
   // Function outputs, row drivers, chaining and interrupt
   // ************************************************************
   logic       primaryFn;
   logic       auxFn;
   logic       irqSource;
   logic       irqSrcLast_reg;
   logic       irqSrcLast_next;
   logic       irq_next;
   logic       chain_next;
   logic       ssN_next;
   logic [3:0] priOut_next;
   logic [3:0] priEn_next;
   logic [3:0] auxOut_next;
   logic [3:0] auxEn_next;

   always_comb begin
      primaryFn = 1'b0;
      auxFn     = 1'b0;
      unique case (functionSelect)
         `DBCR_FN_TIMER: begin
            primaryFn = terminal;
            auxFn     = compareHit;
         end
         `DBCR_FN_COUNTER, `DBCR_FN_PWM: begin
            primaryFn = compareHit;
            auxFn     = terminal;
         end
         `DBCR_FN_PRS, `DBCR_FN_CRC: begin
            primaryFn = count_reg[7];
            auxFn     = compareHit;
         end
         // Serial engines live outside this block; only the slave select
         // path and the data pass-through to the aux output are provided here
         default: begin
            primaryFn = 1'b0;
            auxFn     = COMMS_CAPABLE ? syncIf.level[`DBCR_LN_DATA] : 1'b0;
         end
      endcase
      irqSource = functionMode[`DBCR_MODE_IRQ] ? compareHit : terminal;
      irqSrcLast_next = (run == DBCR_RUNNING) && irqSource;
      irq_next   = irqMask && (run == DBCR_RUNNING) && irqSource && !irqSrcLast_reg; // R17
      chain_next = terminal && chainIn;                                              // R15
      ssN_next   = auxIoEnable ? 1'b0 : syncIf.level[`DBCR_LN_AUX];                  // R2
      priEn_next  = 4'h0;
      auxEn_next  = 4'h0;
      priEn_next[primaryDriverSelect] = primaryDriverEnable;                         // R13
      auxEn_next[auxDriverSelect]     = auxDriverEnable;                             // R13
      priOut_next = {4{primaryFn}} & priEn_next;
      auxOut_next = {4{auxFn}} & auxEn_next;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         irqSrcLast_reg  <= 1'b0;
         irqRequest      <= 1'b0;
         chainOut        <= 1'b0;
         slaveSelectN    <= `DBCR_SS_IDLE;
         primaryRowOut   <= 4'h0;
         primaryRowOutEn <= 4'h0;
         auxRowOut       <= 4'h0;
         auxRowOutEn     <= 4'h0;
         countValue      <= `DBCR_BYTE_RST;
         compareValue    <= `DBCR_BYTE_RST;
      end else begin
         irqSrcLast_reg  <= irqSrcLast_next;
         irqRequest      <= irq_next;
         chainOut        <= chain_next;
         slaveSelectN    <= ssN_next;
         primaryRowOut   <= priOut_next;
         primaryRowOutEn <= priEn_next;
         auxRowOut       <= auxOut_next;
         auxRowOutEn     <= auxEn_next;
         countValue      <= count_next;
         compareValue    <= compare_next;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   sequence seqMasterEdge24;
      tick24 && input_sync_select == `DBCR_SYNC_24M && !clkSel48;
   endsequence

   sequence seqMasterEdge48;
      tick48 && input_sync_select == `DBCR_SYNC_48M && !clkSel48;
   endsequence

   chk_bypass_edge: assert property (@(posedge core_clk) disable iff (!rstn) // R4
      (input_sync_select == `DBCR_SYNC_BYPASS && !clkSel48 && syncIf.rise[0])
      |=> clkEvent_reg)
      else $error("bypass edge did not clock the block");

   chk_resync_24m: assert property (@(posedge core_clk) disable iff (!rstn) // R5
      (clkEvent_reg && $past(input_sync_select == `DBCR_SYNC_24M && !clkSel48))
      |-> $past(tick24))
      else $error("24M resync event off a master edge");

   chk_resync_48m: assert property (@(posedge core_clk) disable iff (!rstn) // R6
      (clkEvent_reg && $past(input_sync_select == `DBCR_SYNC_48M && !clkSel48))
      |-> $past(tick48))
      else $error("48M resync event off a master edge");

   chk_direct_24m: assert property (@(posedge core_clk) disable iff (!rstn) // R7
      (input_sync_select == `DBCR_SYNC_DIRECT && tick24 && !asleep) |=> clkEvent_reg)
      else $error("direct 24M edge lost");

   chk_direct_48m: assert property (@(posedge core_clk) disable iff (!rstn) // R8
      (clkSel48 && input_sync_select != `DBCR_SYNC_DIRECT && tick48 && !asleep)
      |=> clkEvent_reg)
      else $error("direct 48M edge lost");

   chk_sleep_halt: assert property (@(posedge core_clk) disable iff (!rstn) // R11
      (asleep && input_sync_select != `DBCR_SYNC_BYPASS) |=> !clkEvent_reg)
      else $error("synchronized clock ran in sleep");

   chk_single_pulse: assert property (@(posedge core_clk) disable iff (!rstn) // R18
      (seqMasterEdge24 or seqMasterEdge48) ##1 clkEvent_reg |=> !clkEvent_reg)
      else $error("resync pulse longer than one cycle");

   chk_ss_forced: assert property (@(posedge core_clk) disable iff (!rstn) // R2
      auxIoEnable |=> !slaveSelectN)
      else $error("slave select not forced active");

   chk_row_driver: assert property (@(posedge core_clk) disable iff (!rstn) // R13
      primaryDriverEnable |=> primaryRowOutEn == (4'h1 << $past(primaryDriverSelect)))
      else $error("wrong primary row driver enabled");

   chk_reload_period: assert property (@(posedge core_clk) disable iff (!rstn) // R14
      (advance && terminal && functionSelect == `DBCR_FN_TIMER && !writeStrobe)
      |=> count_reg == $past(period_reg))
      else $error("timer did not reload period at terminal count");

   chk_irq_masked: assert property (@(posedge core_clk) disable iff (!rstn) // R17
      !irqMask |=> !irqRequest)
      else $error("interrupt raised while masked");
endmodule : dbcr_block

/* verilog/dbcr_defs.svh */
// Constants of the digital block clock resynchronizer: field codes,
// source indexes and reset values. Definitions only.
// Assumes inclusion by bare name from the package and the design files.
`ifndef DBCR_DEFS_SVH
`define DBCR_DEFS_SVH

// Synchronization select codes
`define DBCR_SYNC_BYPASS   2'h0
`define DBCR_SYNC_24M      2'h1
`define DBCR_SYNC_48M      2'h2
`define DBCR_SYNC_DIRECT   2'h3

// Clock source indexes on the sixteen-way clock selector
`define DBCR_SRC_DIV_ONE   4'h0
`define DBCR_SRC_DIV_TWO   4'h1
`define DBCR_SRC_DIV_THREE 4'h2
`define DBCR_SRC_24M       4'h3
`define DBCR_SRC_48M       4'h4
`define DBCR_SRC_ROW_BASE  4'h5

// Function codes
`define DBCR_FN_TIMER      3'h0
`define DBCR_FN_COUNTER    3'h1
`define DBCR_FN_PWM        3'h2
`define DBCR_FN_PRS        3'h3
`define DBCR_FN_CRC        3'h4
`define DBCR_FN_SPI        3'h5
`define DBCR_FN_UART       3'h6

// Data register select for writes
`define DBCR_WR_COUNT      2'h0
`define DBCR_WR_PERIOD     2'h1
`define DBCR_WR_COMPARE    2'h2
`define DBCR_WR_CONTROL    2'h3

// Field positions
`define DBCR_CTL_ENABLE    0
`define DBCR_MODE_IRQ      0
`define DBCR_MODE_CMP      1

// Reset values
`define DBCR_BYTE_RST      8'h00
`define DBCR_SS_IDLE       1'h1

// Synchronized lane indexes
`define DBCR_LN_CLK        0
`define DBCR_LN_DATA       1
`define DBCR_LN_AUX        2
`define DBCR_LN_24M        3
`define DBCR_LN_48M        4
`define DBCR_LN_SLEEP      5
`define DBCR_LANES         6

`endif

/* verilog/dbcr_pkg.sv */
// Types shared by the resynchronizer and its datapath.
// Assumes dbcr_defs.svh is on the include path.
package dbcr_pkg;
   `include "dbcr_defs.svh"

   typedef logic [7:0] dbcr_byte_t;

   // Datapath run state
   typedef enum logic {
      DBCR_STOPPED,
      DBCR_RUNNING
   } dbcr_run_t;
endpackage : dbcr_pkg

/* verilog/dbcr_sync_if.sv */
// Carrier between the block top and its input synchronizer.
// Assumes one clock domain, core_clk.
`timescale 1ns/1ps
interface dbcr_sync_if #(parameter int LANES = 6);
   logic [LANES-1:0] raw;
   logic [LANES-1:0] level;
   logic [LANES-1:0] rise;
   modport sync (input raw, output level, output rise);
   modport user (output raw, input level, input rise);
endinterface : dbcr_sync_if

/* verilog/dbcr_edge_sync.sv */
// Two-stage synchronizer with rising-edge detect, one lane per input.
// Assumes raw lanes are asynchronous to core_clk; rstn is synchronous.
`timescale 1ns/1ps
module dbcr_edge_sync #(
   parameter int LANES = 6
) (
   input  wire logic core_clk,
   input  wire logic rstn,
   dbcr_sync_if.sync port
);
   initial begin
      if (LANES < 1) $error("dbcr_edge_sync: LANES must be at least 1");
   end

   logic [LANES-1:0] meta_reg;
   logic [LANES-1:0] meta_next;
   logic [LANES-1:0] stable_reg;
   logic [LANES-1:0] stable_next;
   logic [LANES-1:0] last_reg;
   logic [LANES-1:0] last_next;

   always_comb begin
      meta_next   = port.raw;
      stable_next = meta_reg;
      last_next   = stable_reg;
   end

   // First stage feeds only the second stage
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         meta_reg   <= '0;
         stable_reg <= '0;
         last_reg   <= '0;
      end else begin
         meta_reg   <= meta_next;
         stable_reg <= stable_next;
         last_reg   <= last_next;
      end
   end

   assign port.level = stable_reg;
   assign port.rise  = stable_reg & ~last_reg;
endmodule : dbcr_edge_sync

/* verif/dbcr_far_model.sv */
// Far side of the digital block: system clocks, dividers, row and aux lines.
// Assumes the bench commands row pulses and aux levels through its tasks.
`timescale 1ns/1ps
module dbcr_far_model (
   input  wire logic        sleepMode,
   output logic             system_clock_24m,
   output logic             system_clock_48m,
   output logic [2:0]       dividerClocks,
   output logic [10:0]      rowLines,
   output logic [3:0]       auxLines
);
   // ****************************************
   // Master clocks and dividers
   // ****************************************
   initial begin
      system_clock_24m = 1'b0;
      system_clock_48m = 1'b0;
      dividerClocks    = 3'h0;
      rowLines         = 11'h000;
      auxLines         = 4'h0;
   end

   // 24M stops low in sleep, so only bypass can still count
   always #20.833 system_clock_24m = sleepMode ? 1'b0 : ~system_clock_24m;
   always #10.417 system_clock_48m = ~system_clock_48m;

   // Dividers never run at divide-by-one, so no divider matches its master
   always @(posedge system_clock_24m) dividerClocks[0] <= ~dividerClocks[0];
   always @(posedge dividerClocks[0]) dividerClocks[1] <= ~dividerClocks[1];
   always @(posedge system_clock_48m) dividerClocks[2] <= ~dividerClocks[2];

   // ****************************************
   // Row and aux lines
   // ****************************************
   task automatic setRow(input int idx, input logic val);
      rowLines[idx] = val;
   endtask : setRow

   task automatic setAux(input logic [3:0] val);
      auxLines = val;
   endtask : setAux

   // Phases of several core cycles; the 80 ns period is ten core cycles, so each pulse keeps a fixed phase to the core clock
   task automatic pulseRow(input int idx, input int n);
      repeat (n) begin
         #37 rowLines[idx] = 1'b1;
         #43 rowLines[idx] = 1'b0;
      end
   endtask : pulseRow
endmodule : dbcr_far_model

/* verif/tb_top.sv */
// Self-checking bench for dbcr_block with a far-side model.
// Assumes the design package, its header and dbcr_far_model are compiled first.
`timescale 1ns/1ps
module tb_top;
   import dbcr_pkg::*;
   typedef struct {int sel; dbcr_byte_t exp; dbcr_byte_t base;} dbcr_note_t;

   logic core_clk, rstn, system_clock_24m, system_clock_48m, sleepMode;
   logic [2:0] dividerClocks, functionSelect;
   logic [10:0] rowLines;
   logic [3:0] auxSources, clockSelect, dataSelect, primaryRowOutEn, auxRowOutEn;
   logic [1:0] input_sync_select, auxInputSelect, primaryDriverSelect, auxDriverSelect;
   logic [1:0] writeSelect;
   logic auxIoEnable, primaryDriverEnable, auxDriverEnable, writeStrobe, slaveSelectN;
   dbcr_byte_t writeData, countValue, compareValue, per;
   logic [15:0] srcLines;
   dbcr_note_t noteQ[$];
   dbcr_note_t noteNow;
   int miscompares = 0;
   int tests_run = 0;
   int seed = 61;
   logic [3:0] lv;
   event sampleEv;

   assign srcLines = {rowLines, system_clock_48m, system_clock_24m, dividerClocks};

   dbcr_far_model i_far (.sleepMode(sleepMode), .system_clock_24m(system_clock_24m),
      .system_clock_48m(system_clock_48m), .dividerClocks(dividerClocks),
      .rowLines(rowLines), .auxLines(auxSources));

   dbcr_block i_dut (.core_clk(core_clk), .rstn(rstn), .clockSources(srcLines),
      .dataSources(srcLines), .auxSources(auxSources), .system_clock_24m(system_clock_24m),
      .system_clock_48m(system_clock_48m), .sleepMode(sleepMode),
      .functionSelect(functionSelect), .functionMode(2'h0), .clockSelect(clockSelect),
      .dataSelect(dataSelect), .input_sync_select(input_sync_select),
      .auxInputSelect(auxInputSelect), .auxIoEnable(auxIoEnable),
      .primaryDriverSelect(primaryDriverSelect), .primaryDriverEnable(primaryDriverEnable),
      .auxDriverSelect(auxDriverSelect), .auxDriverEnable(auxDriverEnable),
      .writeStrobe(writeStrobe), .writeSelect(writeSelect), .writeData(writeData),
      .chainIn(1'b1), .irqMask(1'b1), .countValue(countValue), .compareValue(compareValue),
      .chainOut(), .irqRequest(), .slaveSelectN(slaveSelectN), .primaryRowOut(),
      .primaryRowOutEn(primaryRowOutEn), .auxRowOut(), .auxRowOutEn(auxRowOutEn));

   always #4 core_clk = ~core_clk;

   // ****************************************
   // Scoreboard
   // ****************************************
   task automatic results;
      if (miscompares == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results

   task automatic cmpByte(input string what, input dbcr_byte_t exp, input dbcr_byte_t seen);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : cmpByte

   task automatic cmpBit(input string what, input logic exp, input logic seen);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %b seen %b", what, exp, seen);
      end
   endtask : cmpBit

   always @(sampleEv) begin
      noteNow = noteQ.pop_front();
      case (noteNow.sel)
         0: cmpByte("countValue", noteNow.exp, countValue);
         1: cmpByte("compareValue", noteNow.exp, compareValue);
         2: cmpByte("primaryRowOutEn", noteNow.exp, {4'h0, primaryRowOutEn});
         3: cmpByte("auxRowOutEn", noteNow.exp, {4'h0, auxRowOutEn});
         4: cmpBit("slaveSelectN", noteNow.exp[0], slaveSelectN);
         default: cmpBit("countMoved", noteNow.exp[0], countValue !== noteNow.base);
      endcase
   end

   // ****************************************
   // Drivers
   // ****************************************
   task automatic note(input int sel, input dbcr_byte_t exp, input dbcr_byte_t base);
      noteQ.push_back('{sel, exp, base});
      -> sampleEv;
      #1;
   endtask : note

   task automatic wr(input logic [1:0] sel, input dbcr_byte_t data);
      @(negedge core_clk);
      writeStrobe = 1'b1;
      writeSelect = sel;
      writeData   = data;
      @(negedge core_clk);
      writeStrobe = 1'b0;
   endtask : wr

   // Stop, repoint the clock path, let the synchronizers settle, reload, run
   task automatic arm(input logic [1:0] sync, input logic [3:0] src);
      wr(`DBCR_WR_CONTROL, 8'h00);
      input_sync_select = sync;
      clockSelect       = src;
      // Two master ticks must pass while stopped, or a stale resync sample
      // left by the previous mode can fire one event after the run starts
      repeat (24) @(negedge core_clk);
      wr(`DBCR_WR_PERIOD, per);
      note(0, per, 8'h00);
      wr(`DBCR_WR_CONTROL, 8'h01);
   endtask : arm

   task automatic tryMode(input logic [1:0] sync, input logic [3:0] src, input logic moved);
      arm(sync, src);
      repeat (200) @(negedge core_clk);
      note(5, {7'h00, moved}, per);
   endtask : tryMode

   initial begin
      #100_000;
      miscompares++;
      results();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      core_clk = 1'b0; rstn = 1'b0; sleepMode = 1'b0;
      functionSelect = `DBCR_FN_TIMER; clockSelect = `DBCR_SRC_ROW_BASE; dataSelect = 4'h7;
      input_sync_select = `DBCR_SYNC_BYPASS; auxInputSelect = 2'h0; auxIoEnable = 1'b0;
      primaryDriverSelect = 2'h0; primaryDriverEnable = 1'b0; auxDriverSelect = 2'h0;
      auxDriverEnable = 1'b0; writeStrobe = 1'b0; writeSelect = 2'h0; writeData = 8'h00;
      repeat (16) @(negedge core_clk);
      note(0, 8'h00, 8'h00);
      note(2, 8'h00, 8'h00);
      note(4, 8'h01, 8'h00);
      rstn = 1'b1;
      per = 8'h80 | 8'($random(seed));
      wr(`DBCR_WR_COMPARE, 8'h03);
      note(1, 8'h03, 8'h00);
      // Bypass from a row line; data row held low so no capture lands
      arm(`DBCR_SYNC_BYPASS, `DBCR_SRC_ROW_BASE);
      i_far.pulseRow(0, 12);
      repeat (8) @(negedge core_clk);
      note(0, per - 8'h0c, 8'h00);
      wr(`DBCR_WR_COMPARE, 8'h77);
      note(1, 8'h03, 8'h00);
      wr(`DBCR_WR_PERIOD, 8'h10);
      note(0, per - 8'h0c, 8'h00);
      tryMode(`DBCR_SYNC_24M, `DBCR_SRC_DIV_ONE, 1'b1);
      tryMode(`DBCR_SYNC_24M, `DBCR_SRC_24M, 1'b0);
      tryMode(`DBCR_SYNC_48M, `DBCR_SRC_DIV_THREE, 1'b1);
      tryMode(`DBCR_SYNC_DIRECT, `DBCR_SRC_ROW_BASE, 1'b1);
      tryMode(`DBCR_SYNC_BYPASS, `DBCR_SRC_48M, 1'b1);
      sleepMode = 1'b1;
      tryMode(`DBCR_SYNC_24M, `DBCR_SRC_DIV_ONE, 1'b0);
      arm(`DBCR_SYNC_BYPASS, `DBCR_SRC_ROW_BASE);
      i_far.pulseRow(0, 5);
      repeat (8) @(negedge core_clk);
      note(0, per - 8'h05, 8'h00);
      sleepMode = 1'b0;
      // Counter gated by the selected data line
      functionSelect = `DBCR_FN_COUNTER;
      arm(`DBCR_SYNC_BYPASS, `DBCR_SRC_ROW_BASE);
      i_far.pulseRow(0, 4);
      repeat (8) @(negedge core_clk);
      note(0, per, 8'h00);
      i_far.setRow(2, 1'b1);
      repeat (8) @(negedge core_clk);
      i_far.pulseRow(0, 4);
      repeat (8) @(negedge core_clk);
      note(0, per - 8'h04, 8'h00);
      // Output drivers, one-hot per select code
      for (int s = 0; s < 4; s++) begin
         primaryDriverSelect = 2'(s);
         auxDriverSelect     = 2'(3 - s);
         primaryDriverEnable = 1'b1;
         auxDriverEnable     = 1'b1;
         repeat (2) @(negedge core_clk);
         note(2, 8'h01 << s, 8'h00);
         note(3, 8'h01 << (3 - s), 8'h00);
      end
      primaryDriverEnable = 1'b0;
      auxDriverEnable     = 1'b0;
      repeat (2) @(negedge core_clk);
      note(2, 8'h00, 8'h00);
      note(3, 8'h00, 8'h00);
      // Slave select: forced, then from each aux line
      functionSelect = `DBCR_FN_SPI;
      auxIoEnable    = 1'b1;
      repeat (6) @(negedge core_clk);
      note(4, 8'h00, 8'h00);
      auxIoEnable = 1'b0;
      for (int k = 0; k < 4; k++) begin
         lv = 4'($random(seed));
         i_far.setAux(lv);
         auxInputSelect = 2'(k);
         repeat (6) @(negedge core_clk);
         note(4, {7'h00, lv[k]}, 8'h00);
      end
      results();
   end
endmodule : tb_top
